// ### include/fault_ctrl_map.vh
// Constants for the switch fault controller: register offsets, field bits, reset values, timing.
// Assumes inclusion by bare name from design files.
`ifndef FAULT_CTRL_MAP_VH
`define FAULT_CTRL_MAP_VH

// Register byte offsets on the Wishbone slave
`define REG_CTRL_ADDR        8'h00
`define REG_STATUS_ADDR      8'h04
`define REG_IRQ_STAT_ADDR    8'h08
`define REG_IRQ_MASK_ADDR    8'h0c
`define REG_LIMIT_ADDR       8'h10

// Control register fields
`define CTRL_FOLDBACK_BIT    0
`define CTRL_RESET_VAL       32'h00000000
`define CTRL_FOLDBACK_RESET  1'b0

// Status register fields
`define ST_SWITCH_ON_BIT     0
`define ST_FAULT_BIT         1
`define ST_OPENLOAD_BIT      2
`define ST_HALVED_BIT        3
`define ST_LOCKOUT_BIT       4
`define ST_REVERSE_BIT       5
`define ST_CNT_LSB           8
`define ST_CNT_MSB           10

// Interrupt event bits
`define IRQ_SHUTDOWN_BIT     0
`define IRQ_FOLDBACK_BIT     1
`define IRQ_OPENLOAD_BIT     2
`define IRQ_LOCKOUT_BIT      3
`define IRQ_WIDTH            4
`define IRQ_RESET_VAL        4'h0

// Current-limit codes
`define LIMIT_CODE_WIDTH     8
`define LIMIT_INTERNAL_CODE  8'h80

// Foldback
`define FOLD_COUNT_MAX       3'h7
`define FOLD_COUNT_ZERO      3'h0

// Timing
`define CLK_PERIOD_NS        5
`define RETRY_TIME_US        1000
`define RETRY_CYCLES         ((`RETRY_TIME_US * 1000) / `CLK_PERIOD_NS)

`endif

// ### design/sync_bits.v
// Two-flop synchroniser for a group of level inputs.
// Assumes each bit is a slowly changing level relative to clk_i.
`timescale 1ns/1ps
`default_nettype none
module sync_bits #(
  parameter WIDTH = 1
) (
  input  wire             clk_i,
  input  wire             rst_i,
  input  wire [WIDTH-1:0] async_i,
  output wire [WIDTH-1:0] sync_o
);
  reg [WIDTH-1:0] meta_reg;
  reg [WIDTH-1:0] stable_reg;
  genvar g;
  generate
    for (g = 0; g < WIDTH; g = g + 1) begin : g_bit
      always @(posedge clk_i) begin
        if (rst_i) begin
          meta_reg[g]   <= 1'b0;
          stable_reg[g] <= 1'b0;
        end else begin
          meta_reg[g]   <= async_i[g];
          stable_reg[g] <= meta_reg[g];
        end
      end
    end
  endgenerate
  assign sync_o = stable_reg;
endmodule
`default_nettype wire

// ### design/limit_select.v
// Chooses the active current-limit code from the resistor code, its validity and foldback.
// Assumes the resistor code and valid flag are already synchronous.
`timescale 1ns/1ps
`default_nettype none
`include "fault_ctrl_map.vh"
module limit_select #(
  parameter W = 8
) (
  input  wire         clk_i,
  input  wire         rst_i,
  input  wire [W-1:0] resistor_code_i,
  input  wire         resistor_valid_i,
  input  wire         halved_i,
  output reg  [W-1:0] limit_o
);
  reg [W-1:0] base;
  always @* begin
    // Floating, grounded or out-of-range resistor falls back to internal level
    if (resistor_valid_i) begin
      base = resistor_code_i;
    end else begin
      base = `LIMIT_INTERNAL_CODE;
    end
  end
  always @(posedge clk_i) begin
    if (rst_i) begin
      limit_o <= `LIMIT_INTERNAL_CODE;
    end else if (halved_i) begin
      limit_o <= {1'b0, base[W-1:1]};
    end else begin
      limit_o <= base;
    end
  end
endmodule
`default_nettype wire

// ### design/switch_fault_ctrl.v
// Fault controller of a single-channel protected high-side switch, with a Wishbone register slave.
// Assumes analog comparators deliver levels; the host drives control pins; one clock clk_i.
// Behaviour
// - Seven consecutive shutdowns halve the limit in foldback
// - Standby or clean on-off cycle restores full limit
// - Non-foldback variant never halves the limit
// - Invalid limit resistor selects internal fixed limit
// - Supply low forces off; recovery resumes operation; a retry from ST_FAULT still turns the switch on for one cycle
// - Overvoltage transient keeps switch state unchanged; code holds it in ST_IDLE and ST_ON only, not during retry
// - Reverse supply turns switch on if grounded
// - Hold-off high keeps switch off after shutdown
// - Hold-off low retries after faults clear, interval
// - Retry keeps fault level until output rises
// - Risen output clears fault, resumes current reporting
// - Off with diagnostic gate enables output comparator
// - Output above open-load threshold signals fault
// - Thermal or overcurrent trip turns off, faults
// - Fault level shown only when sense select low
// - Open-load fault clears on gate fall, enable rise
//
// The placing of the registers and the Wishbone slave port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "fault_ctrl_map.vh"
module switch_fault_ctrl #(
  parameter RETRY_CYCLES = `RETRY_CYCLES,
  parameter LIMIT_W      = `LIMIT_CODE_WIDTH
) (
  input  wire               clk_i,
  input  wire               rst_i,
  input  wire               wb_cyc_i,
  input  wire               wb_stb_i,
  input  wire               wb_we_i,
  input  wire [7:0]         wb_adr_i,
  input  wire [3:0]         wb_sel_i,
  input  wire [31:0]        wb_dat_i,
  output reg  [31:0]        wb_dat_o,
  output reg                wb_ack_o,
  output reg                irq_o,
  input  wire               enable_i,
  input  wire               hold_off_i,
  input  wire               diagnostic_gate_i,
  input  wire               sense_select_i,
  input  wire               sense_select_grounded_i,
  input  wire               thermal_trip_i,
  input  wire               overcurrent_trip_i,
  input  wire               supply_low_i,
  input  wire               supply_over_i,
  input  wire               supply_reverse_i,
  input  wire               output_risen_i,
  input  wire               openload_cmp_i,
  input  wire               standby_i,
  input  wire [LIMIT_W-1:0] limit_resistor_code_i,
  input  wire               limit_resistor_valid_i,
  output reg                switch_on_o,
  output reg                comparator_en_o,
  output reg                sense_fault_o,
  output reg                sense_temp_o,
  output wire [LIMIT_W-1:0] overcurrent_threshold_o
);
  localparam NSYNC = 14;
  localparam ST_IDLE  = 2'h0;
  localparam ST_ON    = 2'h1;
  localparam ST_FAULT = 2'h2;
  localparam ST_RETRY = 2'h3;

  wire [NSYNC-1:0] raw;
  wire [NSYNC-1:0] s;
  assign raw = {limit_resistor_valid_i, standby_i, openload_cmp_i, output_risen_i, supply_reverse_i,
                supply_over_i, supply_low_i, overcurrent_trip_i, thermal_trip_i, sense_select_grounded_i,
                sense_select_i, diagnostic_gate_i, hold_off_i, enable_i};
  // Every asynchronous level passes two flops first
  sync_bits #(.WIDTH(NSYNC)) u_sync (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .async_i (raw),
    .sync_o  (s)
  );
  wire en_s = s[0];
  wire hold_s = s[1];
  wire diag_s = s[2];
  wire sel_s = s[3];
  wire selgnd_s = s[4];
  wire therm_s = s[5];
  wire oc_s = s[6];
  wire low_s = s[7];
  wire over_s = s[8];
  wire rev_s = s[9];
  wire risen_s = s[10];
  wire ol_s = s[11];
  wire stby_s = s[12];
  wire rvalid_s = s[13];

  reg [LIMIT_W-1:0] rcode_m_reg;
  reg [LIMIT_W-1:0] rcode_reg;
  always @(posedge clk_i) begin
    if (rst_i) begin
      rcode_m_reg <= {LIMIT_W{1'b0}};
      rcode_reg   <= {LIMIT_W{1'b0}};
    end else begin
      rcode_m_reg <= limit_resistor_code_i;
      rcode_reg   <= rcode_m_reg;
    end
  end

  reg [1:0]  state_reg;
  reg [1:0]  state_next;
  reg [31:0] retry_cnt_reg;
  reg [2:0]  fold_cnt_reg;
  reg        halved_reg;
  reg        fault_seen_reg;
  reg        openload_reg;
  reg        en_d_reg;
  reg        diag_d_reg;
  reg        foldback_en_reg;
  reg [`IRQ_WIDTH-1:0] irq_stat_reg;
  reg [`IRQ_WIDTH-1:0] irq_mask_reg;

  wire trip = therm_s | oc_s;
  wire retry_done = (retry_cnt_reg == RETRY_CYCLES - 1);
  wire en_rise = en_s & ~en_d_reg;
  wire diag_fall = ~diag_s & diag_d_reg;

  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        // An off switch stays off through an overvoltage transient
        if (en_s && !low_s && !over_s) begin
          state_next = ST_ON;
        end
      end
      ST_ON: begin
        if (trip) begin
          state_next = ST_FAULT;
        end else if (!en_s && !over_s) begin
          state_next = ST_IDLE;
        end
      end
      ST_FAULT: begin
        // Hold-off keeps switch off; low hold-off retries after interval and clearing
        if (!hold_s && retry_done && !trip) begin
          state_next = en_s ? ST_RETRY : ST_IDLE;
        end
      end
      ST_RETRY: begin
        if (trip) begin
          state_next = ST_FAULT;
        end else if (risen_s) begin
          state_next = ST_ON;
        end else if (!en_s) begin
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
    // Supply-low forces off from every state except fault
    if (low_s && state_reg != ST_FAULT) begin
      state_next = ST_IDLE;
    end
  end

  wire entering_fault = (state_next == ST_FAULT) && (state_reg != ST_FAULT);
  wire clean_cycle = (state_reg == ST_ON) && (state_next == ST_IDLE) && !fault_seen_reg;
  wire fold_set = entering_fault && foldback_en_reg && (fold_cnt_reg == `FOLD_COUNT_MAX - 3'h1);
  wire rev_on = rev_s && selgnd_s;
  wire ol_now = (state_reg == ST_IDLE) && !rev_on && diag_s && ol_s;

  always @(posedge clk_i) begin
    if (rst_i) begin
      state_reg      <= ST_IDLE;
      retry_cnt_reg  <= 32'h00000000;
      fold_cnt_reg   <= `FOLD_COUNT_ZERO;
      halved_reg     <= 1'b0;
      fault_seen_reg <= 1'b0;
      openload_reg   <= 1'b0;
      en_d_reg       <= 1'b0;
      diag_d_reg     <= 1'b0;
    end else begin
      state_reg  <= state_next;
      en_d_reg   <= en_s;
      diag_d_reg <= diag_s;
      if (state_reg == ST_FAULT && !retry_done) begin
        retry_cnt_reg <= retry_cnt_reg + 32'h00000001;
      end else if (state_reg != ST_FAULT) begin
        retry_cnt_reg <= 32'h00000000;
      end
      if (state_reg == ST_IDLE) begin
        fault_seen_reg <= 1'b0;
      end else if (entering_fault) begin
        fault_seen_reg <= 1'b1;
      end
      // Counter saturates at seven, clears on standby or clean cycle
      if (stby_s || clean_cycle) begin
        fold_cnt_reg <= `FOLD_COUNT_ZERO;
      end else if (entering_fault && fold_cnt_reg != `FOLD_COUNT_MAX) begin
        fold_cnt_reg <= fold_cnt_reg + 3'h1;
      end
      // Halving only with foldback enabled
      if (!foldback_en_reg || stby_s || clean_cycle) begin
        halved_reg <= 1'b0;
      end else if (fold_set) begin
        halved_reg <= 1'b1;
      end
      // Open-load flag follows comparator, clears on edges
      if (diag_fall || en_rise || state_reg != ST_IDLE) begin
        openload_reg <= 1'b0;
      end else begin
        openload_reg <= ol_now;
      end
    end
  end

  wire in_fault = (state_reg == ST_FAULT) || (state_reg == ST_RETRY);
  wire sw_on = (state_reg == ST_ON) || (state_reg == ST_RETRY) || rev_on;

  limit_select #(.W(LIMIT_W)) u_limit (
    .clk_i            (clk_i),
    .rst_i            (rst_i),
    .resistor_code_i  (rcode_reg),
    .resistor_valid_i (rvalid_s),
    .halved_i         (halved_reg),
    .limit_o          (overcurrent_threshold_o)
  );

  always @(posedge clk_i) begin
    if (rst_i) begin
      switch_on_o     <= 1'b0;
      comparator_en_o <= 1'b0;
      sense_fault_o   <= 1'b0;
      sense_temp_o    <= 1'b0;
    end else begin
      switch_on_o     <= sw_on;
      comparator_en_o <= (state_reg == ST_IDLE) && !rev_on && diag_s;
      sense_fault_o   <= diag_s && !sel_s && (in_fault || openload_reg);
      sense_temp_o    <= diag_s && sel_s;
    end
  end

  // Wishbone slave
  wire wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire wb_wr = wb_req && wb_we_i;
  wire [`IRQ_WIDTH-1:0] events = {low_s & (state_reg != ST_IDLE), ol_now & ~openload_reg, fold_set, entering_fault};
  wire [`IRQ_WIDTH-1:0] w1c = (wb_wr && wb_adr_i == `REG_IRQ_STAT_ADDR && wb_sel_i[0]) ? wb_dat_i[`IRQ_WIDTH-1:0] :
                              {`IRQ_WIDTH{1'b0}};
  reg [31:0] rd;
  always @* begin
    rd = 32'h00000000;
    if (wb_adr_i == `REG_CTRL_ADDR) begin
      rd[`CTRL_FOLDBACK_BIT] = foldback_en_reg;
    end else if (wb_adr_i == `REG_STATUS_ADDR) begin
      rd[`ST_SWITCH_ON_BIT] = switch_on_o;
      rd[`ST_FAULT_BIT] = in_fault;
      rd[`ST_OPENLOAD_BIT] = openload_reg;
      rd[`ST_HALVED_BIT] = halved_reg;
      rd[`ST_LOCKOUT_BIT] = low_s;
      rd[`ST_REVERSE_BIT] = rev_s;
      rd[`ST_CNT_MSB:`ST_CNT_LSB] = fold_cnt_reg;
    end else if (wb_adr_i == `REG_IRQ_STAT_ADDR) begin
      rd[`IRQ_WIDTH-1:0] = irq_stat_reg;
    end else if (wb_adr_i == `REG_IRQ_MASK_ADDR) begin
      rd[`IRQ_WIDTH-1:0] = irq_mask_reg;
    end else if (wb_adr_i == `REG_LIMIT_ADDR) begin
      rd[LIMIT_W-1:0] = overcurrent_threshold_o;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o        <= 1'b0;
      wb_dat_o        <= 32'h00000000;
      foldback_en_reg <= `CTRL_FOLDBACK_RESET;
      irq_stat_reg    <= `IRQ_RESET_VAL;
      irq_mask_reg    <= `IRQ_RESET_VAL;
      irq_o           <= 1'b0;
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= wb_req ? rd : 32'h00000000;
      if (wb_wr && wb_adr_i == `REG_CTRL_ADDR && wb_sel_i[0]) begin
        foldback_en_reg <= wb_dat_i[`CTRL_FOLDBACK_BIT];
      end
      if (wb_wr && wb_adr_i == `REG_IRQ_MASK_ADDR && wb_sel_i[0]) begin
        irq_mask_reg <= wb_dat_i[`IRQ_WIDTH-1:0];
      end
      // Set wins over clear
      irq_stat_reg <= (irq_stat_reg & ~w1c) | events;
      irq_o <= |(((irq_stat_reg & ~w1c) | events) & irq_mask_reg);
    end
  end
endmodule
`default_nettype wire

// ### verif/switch_fault_ctrl_assertions.sv
// Port checker for the switch fault controller.
// Assumes one clock clk_i and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module fault_ctrl_chk (
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic       wb_cyc_i,
  input wire logic       wb_stb_i,
  input wire logic       wb_ack_o,
  input wire logic       enable_i,
  input wire logic       diagnostic_gate_i,
  input wire logic       sense_select_i,
  input wire logic       sense_select_grounded_i,
  input wire logic       thermal_trip_i,
  input wire logic       overcurrent_trip_i,
  input wire logic       supply_low_i,
  input wire logic       supply_reverse_i,
  input wire logic       openload_cmp_i,
  input wire logic       limit_resistor_valid_i,
  input wire logic       switch_on_o,
  input wire logic       comparator_en_o,
  input wire logic       sense_fault_o,
  input wire logic [7:0] overcurrent_threshold_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_pulse: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bad ack");
  a_reverse_on: assert property ((supply_reverse_i && sense_select_grounded_i) [*6] |-> switch_on_o)
    else $error("reverse not on");
  a_lockout_off: assert property ((supply_low_i && !supply_reverse_i) [*6] |-> !switch_on_o)
    else $error("on in lockout");
  a_trip_off: assert property (((thermal_trip_i || overcurrent_trip_i) && !supply_reverse_i) [*6] |-> !switch_on_o)
    else $error("on during trip");
  a_select_temp: assert property (sense_select_i [*4] |-> !sense_fault_o)
    else $error("fault with select high");
  a_comp_gate: assert property (!diagnostic_gate_i [*4] |-> !comparator_en_o)
    else $error("comparator without gate");
  a_openload_flag: assert property ((diagnostic_gate_i && !sense_select_i && openload_cmp_i
    && !enable_i && !switch_on_o) [*6] |-> sense_fault_o)
    else $error("open load not shown");
  a_limit_fallback: assert property (!limit_resistor_valid_i [*6] |->
    overcurrent_threshold_o == 8'h80 || overcurrent_threshold_o == 8'h40)
    else $error("no internal limit");
  cover property ($rose(switch_on_o));
  cover property ($rose(sense_fault_o));
  cover property ($changed(overcurrent_threshold_o));
endmodule
bind switch_fault_ctrl fault_ctrl_chk i_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .enable_i,
  .diagnostic_gate_i, .sense_select_i, .sense_select_grounded_i, .thermal_trip_i, .overcurrent_trip_i,
  .supply_low_i, .supply_reverse_i, .openload_cmp_i, .limit_resistor_valid_i, .switch_on_o,
  .comparator_en_o, .sense_fault_o, .overcurrent_threshold_o);
`default_nettype wire

// ### verif/load_model.sv
// Model of the load and output node at the switch output.
// Assumes the switch drive is a registered level on clk_i.
`timescale 1ns/1ps
`default_nettype none
module load_model #(
  parameter RISE = 3
) (
  input  wire logic clk_i,
  input  wire logic switch_on_i,
  input  wire logic shorted_i,
  input  wire logic open_i,
  output wire logic risen_o,
  output wire logic cmp_o
);
  logic [3:0] cnt_reg;
  // Output node rises some cycles after turn-on, never while shorted
  always @(posedge clk_i) begin
    if (!switch_on_i || shorted_i) begin
      cnt_reg <= 4'h0;
    end else if (cnt_reg != RISE) begin
      cnt_reg <= cnt_reg + 4'h1;
    end
  end
  assign risen_o = switch_on_i && !shorted_i && cnt_reg == RISE;
  // Off-state node sits above threshold when the load is open
  assign cmp_o   = open_i && !switch_on_i;
endmodule
`default_nettype wire

// ### verif/switch_fault_ctrl_tb.sv
// Self-checking bench for the switch fault controller.
// Assumes a 200 MHz clock and a shortened restart interval.
`timescale 1ns/1ps
`default_nettype none
`include "fault_ctrl_map.vh"
module switch_fault_ctrl_tb;
  logic        clk_i = 1'h0, rst_i = 1'h1, wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0, wb_ack_o, irq_o;
  logic [7:0]  wb_adr_i = 8'h00, limit_resistor_code_i = 8'h64, overcurrent_threshold_o;
  logic [3:0]  wb_sel_i = 4'h1;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
  logic        enable_i = 1'h0, hold_off_i = 1'h0, diagnostic_gate_i = 1'h1, sense_select_i = 1'h0;
  logic        sense_select_grounded_i = 1'h0, thermal_trip_i = 1'h0, overcurrent_trip_i = 1'h0;
  logic        supply_low_i = 1'h1, supply_over_i = 1'h0, supply_reverse_i = 1'h0, standby_i = 1'h0;
  logic        limit_resistor_valid_i = 1'h1, shorted = 1'h0, open_ld = 1'h0, output_risen_i, openload_cmp_i;
  logic        switch_on_o, comparator_en_o, sense_fault_o, sense_temp_o;
  int          fails = 0, checks_done = 0;
  always #2.5 clk_i = ~clk_i;
  switch_fault_ctrl #(.RETRY_CYCLES(8)) i_dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .irq_o, .enable_i, .hold_off_i, .diagnostic_gate_i,
    .sense_select_i, .sense_select_grounded_i, .thermal_trip_i, .overcurrent_trip_i, .supply_low_i,
    .supply_over_i, .supply_reverse_i, .output_risen_i, .openload_cmp_i, .standby_i, .limit_resistor_code_i,
    .limit_resistor_valid_i, .switch_on_o, .comparator_en_o, .sense_fault_o, .sense_temp_o,
    .overcurrent_threshold_o);
  load_model i_load (.clk_i, .switch_on_i(switch_on_o), .shorted_i(shorted), .open_i(open_ld),
    .risen_o(output_risen_i), .cmp_o(openload_cmp_i));
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic bail;
    fails++;
    print_verdict();
  endtask
  task automatic ck(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int i;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'h3, we, a, d};
    for (i = 0; i < 20 && wb_ack_o !== 1'h1; i++) @(posedge clk_i);
    if (i == 20) bail();
    rd = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'h0;
    @(posedge clk_i);
  endtask
  task automatic wsw(input logic v);
    int i;
    @(posedge clk_i);
    for (i = 0; i < 60 && switch_on_o !== v; i++) @(posedge clk_i);
    if (i == 60) bail();
  endtask
  task automatic trips(input int n);
    repeat (n) begin
      overcurrent_trip_i <= 1'h1;
      wsw(1'h0);
      overcurrent_trip_i <= 1'h0;
      wsw(1'h1);
      repeat (8) @(posedge clk_i);
    end
  endtask
  task automatic clean;
    enable_i <= 1'h0;
    wsw(1'h0);
    enable_i <= 1'h1;
    wsw(1'h1);
    enable_i <= 1'h0;
    wsw(1'h0);
  endtask
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'h0;
    ck(overcurrent_threshold_o, `LIMIT_INTERNAL_CODE);
    wb(1'h0, `REG_CTRL_ADDR, 32'h0);
    ck(rd, `CTRL_RESET_VAL);
    wb(1'h1, 8'h20, 32'hff);
    wb(1'h0, 8'h20, 32'h0);
    ck(rd, 32'h0);
    wb(1'h0, `REG_LIMIT_ADDR, 32'h0);
    ck(rd, 32'h64);
    supply_low_i <= 1'h0;
    repeat (4) @(posedge clk_i);
    enable_i <= 1'h1;
    wsw(1'h1);
    trips(8);
    ck(overcurrent_threshold_o, 8'h64);
    ck(irq_o, 32'h0);
    wb(1'h1, `REG_IRQ_MASK_ADDR, 32'h1);
    wb(1'h0, `REG_IRQ_MASK_ADDR, 32'h0);
    ck(rd, 32'h1);
    wb(1'h0, `REG_IRQ_STAT_ADDR, 32'h0);
    ck({rd[0], irq_o}, 32'h3);
    wb(1'h1, `REG_IRQ_STAT_ADDR, 32'h1);
    repeat (2) @(posedge clk_i);
    ck(irq_o, 32'h0);
    shorted <= 1'h1;
    trips(1);
    ck({switch_on_o, sense_fault_o}, 32'h3);
    shorted <= 1'h0;
    repeat (8) @(posedge clk_i);
    ck(sense_fault_o, 32'h0);
    clean;
    wb(1'h1, `REG_CTRL_ADDR, 32'h1);
    enable_i <= 1'h1;
    wsw(1'h1);
    trips(6);
    ck(overcurrent_threshold_o, 8'h64);
    trips(1);
    ck(overcurrent_threshold_o, 8'h32);
    {standby_i, enable_i} <= 2'h2;
    repeat (8) @(posedge clk_i);
    ck(overcurrent_threshold_o, 8'h64);
    {standby_i, enable_i} <= 2'h1;
    wsw(1'h1);
    trips(7);
    ck(overcurrent_threshold_o, 8'h32);
    clean;
    ck(overcurrent_threshold_o, 8'h64);
    limit_resistor_valid_i <= 1'h0;
    repeat (6) @(posedge clk_i);
    ck(overcurrent_threshold_o, 8'h80);
    {limit_resistor_valid_i, enable_i, hold_off_i} <= 3'h7;
    wsw(1'h1);
    thermal_trip_i <= 1'h1;
    wsw(1'h0);
    thermal_trip_i <= 1'h0;
    repeat (40) @(posedge clk_i);
    ck(switch_on_o, 32'h0);
    hold_off_i <= 1'h0;
    wsw(1'h1);
    repeat (8) @(posedge clk_i);
    {supply_over_i, enable_i} <= 2'h2;
    repeat (10) @(posedge clk_i);
    ck(switch_on_o, 32'h1);
    {supply_over_i, enable_i, supply_low_i} <= 3'h3;
    repeat (8) @(posedge clk_i);
    ck(switch_on_o, 32'h0);
    supply_low_i <= 1'h0;
    wsw(1'h1);
    enable_i <= 1'h0;
    wsw(1'h0);
    {supply_over_i, enable_i} <= 2'h3;
    repeat (8) @(posedge clk_i);
    ck(switch_on_o, 32'h0);
    {supply_over_i, enable_i, supply_reverse_i} <= 3'h1;
    repeat (8) @(posedge clk_i);
    ck(switch_on_o, 32'h0);
    sense_select_grounded_i <= 1'h1;
    repeat (8) @(posedge clk_i);
    ck(switch_on_o, 32'h1);
    {supply_reverse_i, open_ld} <= 2'h1;
    repeat (10) @(posedge clk_i);
    ck({comparator_en_o, sense_fault_o}, 32'h3);
    sense_select_i <= 1'h1;
    repeat (6) @(posedge clk_i);
    ck({sense_fault_o, sense_temp_o}, 32'h1);
    {sense_select_i, diagnostic_gate_i} <= 2'h0;
    repeat (6) @(posedge clk_i);
    wb(1'h0, `REG_STATUS_ADDR, 32'h0);
    ck(rd[2], 32'h0);
    wb(1'h0, `REG_IRQ_STAT_ADDR, 32'h0);
    ck(rd, 32'hf);
    ck(irq_o, 32'h1);
    print_verdict();
  end
endmodule
`default_nettype wire
